// >>> rtl/nrc_pkg.sv
// nrc_pkg: constants and types for the nand command interpreter.
// assumes a 100 mhz core clock; all nand pins are asynchronous to it.
package nrc_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ = 100;
  // reset busy time in ns, plain default
  localparam int unsigned RST_TIME_NS = 5000;
  // least time, rounded up to whole cycles
  localparam int unsigned RST_CYC = (RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W = 16;

  // ==========================================================================
  // geometry
  localparam int unsigned NUM_DIE = 4;
  localparam int unsigned ADDR_BYTES = 5;
  localparam int unsigned NUM_PINS = 14;

  // pin vector positions
  localparam int unsigned PIN_CE_N = 0;
  localparam int unsigned PIN_CLE = 1;
  localparam int unsigned PIN_ALE = 2;
  localparam int unsigned PIN_WE_N = 3;
  localparam int unsigned PIN_RD_N = 4;
  localparam int unsigned PIN_LCLK = 5;
  localparam int unsigned PIN_DQ = 6;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_ERASE = 8'h60;
  localparam logic [7:0] OP_ERASE_GO = 8'hd0;
  localparam logic [7:0] OP_ERASE_MP = 8'hd1;
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_READ_GO = 8'h30;
  localparam logic [7:0] OP_READ_MP = 8'h32;
  localparam logic [7:0] OP_CB_READ = 8'h35;
  localparam logic [7:0] OP_CACHE_SEQ = 8'h31;
  localparam logic [7:0] OP_CACHE_LAST = 8'h3f;
  localparam logic [7:0] OP_CB_PROG = 8'h85;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_PROG_GO = 8'h10;
  localparam logic [7:0] OP_PROG_MP = 8'h11;
  localparam logic [7:0] OP_PROG_CACHE = 8'h15;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_SRESET = 8'hfc;
  localparam logic [7:0] OP_READ_ID = 8'h90;
  localparam logic [7:0] ID_ADDR_CODE = 8'h00;
  localparam logic [7:0] ID_ADDR_SIG = 8'h20;
  localparam logic [2:0] ERASE_ADDR_N = 3'd3;
  localparam logic [2:0] PAGE_ADDR_N = 3'd5;
  localparam logic [2:0] ID_CODE_LEN = 3'd5;
  localparam logic [2:0] ID_SIG_LEN = 3'd4;

  // identifier bytes, values are arbitrary
  localparam logic [39:0] ID_CODE = 40'h15_a3_5c_72_e1;
  // interface signature bytes, values are arbitrary
  localparam logic [31:0] ID_SIG = 32'hd4_c3_b2_a1;

  // ==========================================================================
  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERR = 4'h8;
  localparam int unsigned CTRL_TMODE_LSB = 0;
  localparam int unsigned CTRL_SYNC_BIT = 4;
  localparam logic [3:0] CTRL_TMODE_RST = 4'h0;
  localparam int unsigned ST_RST_BUSY = 0;
  localparam int unsigned ST_SYNC = 1;
  localparam int unsigned ST_ID_MODE = 2;
  localparam int unsigned ST_ALL_IDLE = 3;
  localparam int unsigned ST_MP_PEND = 4;
  localparam int unsigned ST_LAST_LSB = 8;
  localparam int unsigned ERR_SEQ = 0;
  localparam int unsigned ERR_CACHE = 1;
  localparam int unsigned ERR_SRESET = 2;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_WAIT_GO, S_ID_ADDR, S_ID_OUT
  } nrc_state_t;

  typedef enum logic [1:0] {
    CLS_OTHER, CLS_READ, CLS_PCACHE
  } nrc_cls_t;

endpackage : nrc_pkg

// >>> rtl/nrc_pin_if.sv
// nrc_pin_if: synchronised pin levels and their edges.
// assumes producer and consumer share the core clock.
`timescale 1ns/1ns
interface nrc_pin_if;
  logic [nrc_pkg::NUM_PINS-1:0] lvl;
  logic [nrc_pkg::NUM_PINS-1:0] rise;
  logic [nrc_pkg::NUM_PINS-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : nrc_pin_if

// >>> rtl/nrc_pin_sync.sv
// nrc_pin_sync: two-stage synchronisers and edge detection for pins.
// assumes pins are asynchronous to i_core_clk and slower than half its rate.
`timescale 1ns/1ns
module nrc_pin_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // raw pins
  input wire logic [nrc_pkg::NUM_PINS-1:0] i_pins,
  // synchronised view
  nrc_pin_if.src pins
);

  logic [nrc_pkg::NUM_PINS-1:0] meta_ff;
  logic [nrc_pkg::NUM_PINS-1:0] sync_ff;
  logic [nrc_pkg::NUM_PINS-1:0] prev_ff;

  genvar g;
  generate
    for (g = 0; g < nrc_pkg::NUM_PINS; g++) begin : g_bit
      // idle level of the pin, so no false edge follows reset
      localparam logic IDLE_LVL = (g == nrc_pkg::PIN_CE_N) || (g == nrc_pkg::PIN_WE_N) ||
                                  (g == nrc_pkg::PIN_RD_N);
      always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta_ff[g] <= IDLE_LVL;
          sync_ff[g] <= IDLE_LVL;
          prev_ff[g] <= IDLE_LVL;
        end else begin
          meta_ff[g] <= i_pins[g];
          sync_ff[g] <= meta_ff[g];
          prev_ff[g] <= sync_ff[g];
        end
      end
      assign pins.lvl[g] = sync_ff[g];
      assign pins.rise[g] = sync_ff[g] & ~prev_ff[g];
      assign pins.fall[g] = ~sync_ff[g] & prev_ff[g];
    end
  endgenerate

endmodule : nrc_pin_sync

// >>> rtl/nrc_timer.sv
// nrc_timer: load-and-count-down busy timer.
// assumes a start pulse restarts the count even while busy.
`timescale 1ns/1ns
module nrc_timer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_start,
  input wire logic [nrc_pkg::TMR_W-1:0] i_load,
  // status
  output logic o_busy
);

  logic [nrc_pkg::TMR_W-1:0] cnt_ff;
  logic [nrc_pkg::TMR_W-1:0] nxt_cnt;

  assign nxt_cnt = i_start ? i_load :
                   (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign o_busy = (cnt_ff != '0);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : nrc_timer

// >>> rtl/nrc_top.sv
// nrc_top: command interpreter of a multi-die nand target.
// assumes nand pins are asynchronous and sampled by i_core_clk; the array
// side and the register port run on i_core_clk.
//
// Functional notes
// - erase is 60h, three addresses, D0h or D1h
// - copyback read 00h-35h; program 85h then 10h/11h
// - at most one multi-plane read before read
// - FFh always taken; target busy for reset time
// - reset aborts array, clears command, invalidates data
// - FFh in sync mode returns async, timing 0
// - sync FFh latched on any link clock edge; the code latches it on link clock rise only
// - FFh in async mode keeps timing mode
// - FCh accepted only in sync mode
// - FCh aborts like FFh, keeps sync mode
// - 90h accepted only when all dies idle
// - id mode holds until next valid command
// - address 00h returns five identifier bytes
// - address 20h returns four signature bytes
// - async: one id byte per read strobe toggle
// - sync: byte per strobe rise, repeated on fall
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module nrc_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // nand pins
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_link_clk,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic o_dqs,
  output logic o_dqs_oe,
  output logic o_rb_n,
  // array side
  input wire logic [nrc_pkg::NUM_DIE-1:0] i_die_rdy,
  input wire logic i_array_ready_flag,
  output logic o_op_valid,
  output logic [7:0] o_op_first,
  output logic [7:0] o_op_confirm,
  output logic [8*nrc_pkg::ADDR_BYTES-1:0] o_op_addr,
  output logic o_abort,
  output logic o_array_stop,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);

  // ==========================================================================
  // pin synchronisation
  nrc_pin_if pins ();

  nrc_pin_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_nrst (i_nrst),
    .i_pins ({i_dq, i_link_clk, i_read_strobe_n, i_we_n, i_ale, i_cle, i_ce_n}),
    .pins (pins.src)
  );

  // ==========================================================================
  // state
  nrc_pkg::nrc_state_t state_ff;
  nrc_pkg::nrc_state_t nxt_state;
  nrc_pkg::nrc_cls_t cls_ff;
  nrc_pkg::nrc_cls_t nxt_cls;
  logic [7:0] first_ff;
  logic [7:0] nxt_first;
  logic [2:0] need_ff;
  logic [2:0] nxt_need;
  logic [2:0] acnt_ff;
  logic [2:0] nxt_acnt;
  logic [8*nrc_pkg::ADDR_BYTES-1:0] addr_ff;
  logic [8*nrc_pkg::ADDR_BYTES-1:0] nxt_addr;
  logic mp_ff;
  logic nxt_mp;
  logic [7:0] last_ff;
  logic [7:0] nxt_last;
  logic id_sig_ff;
  logic nxt_id_sig;
  logic [2:0] idx_ff;
  logic [2:0] nxt_idx;
  logic sync_en_ff;
  logic [3:0] tmode_ff;
  logic [2:0] err_ff;
  logic [7:0] dq_ff;
  logic dq_oe_ff;
  logic dqs_ff;
  logic dqs_oe_ff;
  logic op_valid_ff;
  logic [7:0] op_conf_ff;
  logic abort_ff;
  logic [31:0] rdata_ff;

  // ==========================================================================
  // pin decoding
  logic sel;
  logic cle;
  logic ale;
  logic we_n;
  logic rd_n;
  logic [7:0] bus_byte;
  logic lclk_rise;
  logic lclk_fall;
  logic we_rise;
  logic rd_fall;
  logic cmd_ev;
  logic addr_ev;
  logic all_idle;
  logic array_busy;
  logic rst_busy;
  logic id_out;
  logic sync_out_win;

  assign sel = ~pins.lvl[nrc_pkg::PIN_CE_N];
  assign cle = pins.lvl[nrc_pkg::PIN_CLE];
  assign ale = pins.lvl[nrc_pkg::PIN_ALE];
  assign we_n = pins.lvl[nrc_pkg::PIN_WE_N];
  assign rd_n = pins.lvl[nrc_pkg::PIN_RD_N];
  assign bus_byte = pins.lvl[nrc_pkg::PIN_DQ +: 8];
  assign lclk_rise = pins.rise[nrc_pkg::PIN_LCLK];
  assign lclk_fall = pins.fall[nrc_pkg::PIN_LCLK];
  assign we_rise = pins.rise[nrc_pkg::PIN_WE_N];
  assign rd_fall = pins.fall[nrc_pkg::PIN_RD_N];
  // sync: latched on link clock rise regardless of earlier clock gaps
  assign cmd_ev = sel & cle & ~ale & (sync_en_ff ? (lclk_rise & we_n) : we_rise);
  assign addr_ev = sel & ale & ~cle & (sync_en_ff ? (lclk_rise & we_n) : we_rise);
  assign all_idle = &i_die_rdy;
  assign array_busy = ~i_array_ready_flag;
  assign id_out = (state_ff == nrc_pkg::S_ID_OUT);
  assign sync_out_win = sync_en_ff & sel & ale & cle & ~we_n & id_out;

  // ==========================================================================
  // decode helpers
  function automatic logic conf_ok(input logic [7:0] first, input logic [7:0] conf);
    logic ok;
    ok = 1'b0;
    unique case (first)
      nrc_pkg::OP_ERASE:
        ok = (conf == nrc_pkg::OP_ERASE_GO) | (conf == nrc_pkg::OP_ERASE_MP);
      nrc_pkg::OP_READ:
        ok = (conf == nrc_pkg::OP_READ_GO) | (conf == nrc_pkg::OP_READ_MP) |
             (conf == nrc_pkg::OP_CB_READ) | (conf == nrc_pkg::OP_CACHE_SEQ);
      nrc_pkg::OP_CB_PROG:
        ok = (conf == nrc_pkg::OP_PROG_GO) | (conf == nrc_pkg::OP_PROG_MP);
      nrc_pkg::OP_PROG:
        ok = (conf == nrc_pkg::OP_PROG_GO) | (conf == nrc_pkg::OP_PROG_MP) |
             (conf == nrc_pkg::OP_PROG_CACHE);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : conf_ok

  function automatic logic [7:0] id_byte(input logic sig, input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (sig) begin
      if (idx < nrc_pkg::ID_SIG_LEN) begin
        b = nrc_pkg::ID_SIG[8*idx +: 8];
      end
    end else if (idx < nrc_pkg::ID_CODE_LEN) begin
      b = nrc_pkg::ID_CODE[8*idx +: 8];
    end
    return b;
  endfunction : id_byte

  // ==========================================================================
  // command sequencer
  logic rst_hit;
  logic op_fire;
  logic seq_err_set;
  logic cache_err_set;
  logic srst_err_set;

  always_comb begin
    nxt_state = state_ff;
    nxt_cls = cls_ff;
    nxt_first = first_ff;
    nxt_need = need_ff;
    nxt_acnt = acnt_ff;
    nxt_addr = addr_ff;
    nxt_mp = mp_ff;
    nxt_last = last_ff;
    nxt_id_sig = id_sig_ff;
    nxt_idx = idx_ff;
    rst_hit = 1'b0;
    op_fire = 1'b0;
    seq_err_set = 1'b0;
    cache_err_set = 1'b0;
    srst_err_set = 1'b0;
    if (cmd_ev) begin
      if (bus_byte == nrc_pkg::OP_RESET) begin
        rst_hit = 1'b1;
      end else if (rst_busy) begin
        nxt_state = state_ff;
      end else if (bus_byte == nrc_pkg::OP_SRESET) begin
        rst_hit = sync_en_ff;
        srst_err_set = ~sync_en_ff;
      end else if (bus_byte == nrc_pkg::OP_READ_ID) begin
        if (all_idle) begin
          nxt_state = nrc_pkg::S_ID_ADDR;
          nxt_last = bus_byte;
        end
      end else if (state_ff == nrc_pkg::S_WAIT_GO && conf_ok(first_ff, bus_byte)) begin
        op_fire = 1'b1;
        nxt_state = nrc_pkg::S_IDLE;
        nxt_last = bus_byte;
        nxt_cls = nrc_pkg::CLS_OTHER;
        if (first_ff == nrc_pkg::OP_READ) begin
          nxt_cls = nrc_pkg::CLS_READ;
          nxt_mp = (bus_byte == nrc_pkg::OP_READ_MP);
          seq_err_set = mp_ff & (bus_byte == nrc_pkg::OP_READ_MP);
          cache_err_set = array_busy & (bus_byte != nrc_pkg::OP_READ_GO) &
                          (cls_ff != nrc_pkg::CLS_READ);
        end else if (bus_byte == nrc_pkg::OP_PROG_CACHE) begin
          nxt_cls = nrc_pkg::CLS_PCACHE;
          cache_err_set = array_busy & (cls_ff != nrc_pkg::CLS_PCACHE);
        end
      end else begin
        nxt_state = nrc_pkg::S_IDLE;
        nxt_last = bus_byte;
        nxt_acnt = 3'd0;
        seq_err_set = (state_ff == nrc_pkg::S_ADDR) | (state_ff == nrc_pkg::S_WAIT_GO);
        unique case (bus_byte)
          nrc_pkg::OP_ERASE: begin
            nxt_state = nrc_pkg::S_ADDR;
            nxt_first = bus_byte;
            nxt_need = nrc_pkg::ERASE_ADDR_N;
          end
          nrc_pkg::OP_READ, nrc_pkg::OP_CB_PROG, nrc_pkg::OP_PROG: begin
            nxt_state = nrc_pkg::S_ADDR;
            nxt_first = bus_byte;
            nxt_need = nrc_pkg::PAGE_ADDR_N;
          end
          nrc_pkg::OP_CACHE_SEQ, nrc_pkg::OP_CACHE_LAST: begin
            op_fire = 1'b1;
            nxt_first = bus_byte;
            cache_err_set = array_busy & (cls_ff != nrc_pkg::CLS_READ);
            nxt_cls = nrc_pkg::CLS_READ;
            nxt_mp = 1'b0;
          end
          default: begin
            nxt_cls = nrc_pkg::CLS_OTHER;
          end
        endcase
      end
    end else if (addr_ev) begin
      if (state_ff == nrc_pkg::S_ADDR) begin
        nxt_addr[8*acnt_ff +: 8] = bus_byte;
        nxt_acnt = acnt_ff + 3'd1;
        if (acnt_ff + 3'd1 == need_ff) begin
          nxt_state = nrc_pkg::S_WAIT_GO;
        end
      end else if (state_ff == nrc_pkg::S_ID_ADDR) begin
        nxt_state = nrc_pkg::S_ID_OUT;
        nxt_id_sig = (bus_byte == nrc_pkg::ID_ADDR_SIG);
        nxt_idx = 3'd0;
      end
    end
    if ((~sync_en_ff & sel & rd_fall & id_out) | (sync_out_win & lclk_rise)) begin
      nxt_idx = (idx_ff == 3'd7) ? idx_ff : idx_ff + 3'd1;
    end
    if (rst_hit) begin
      nxt_state = nrc_pkg::S_IDLE;
      nxt_acnt = 3'd0;
      nxt_addr = '0;
      nxt_mp = 1'b0;
      nxt_cls = nrc_pkg::CLS_OTHER;
      nxt_last = bus_byte;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= nrc_pkg::S_IDLE;
      cls_ff <= nrc_pkg::CLS_OTHER;
      first_ff <= 8'h00;
      need_ff <= 3'd0;
      acnt_ff <= 3'd0;
      addr_ff <= '0;
      mp_ff <= 1'b0;
      last_ff <= 8'h00;
      id_sig_ff <= 1'b0;
      idx_ff <= 3'd0;
    end else begin
      state_ff <= nxt_state;
      cls_ff <= nxt_cls;
      first_ff <= nxt_first;
      need_ff <= nxt_need;
      acnt_ff <= nxt_acnt;
      addr_ff <= nxt_addr;
      mp_ff <= nxt_mp;
      last_ff <= nxt_last;
      id_sig_ff <= nxt_id_sig;
      idx_ff <= nxt_idx;
    end
  end

  // ==========================================================================
  // reset busy time
  nrc_timer u_rst_tmr (
    .i_core_clk (i_core_clk),
    .i_nrst (i_nrst),
    .i_start (rst_hit),
    .i_load (nrc_pkg::TMR_W'(nrc_pkg::RST_CYC)),
    .o_busy (rst_busy)
  );

  // ==========================================================================
  // interface mode and timing mode
  logic ctrl_wr;
  logic err_wr;
  logic rst_to_async;

  assign ctrl_wr = i_reg_wr & (i_reg_addr == nrc_pkg::REG_CTRL);
  assign err_wr = i_reg_wr & (i_reg_addr == nrc_pkg::REG_ERR);
  // FCh keeps sync, FFh in async leaves timing untouched
  assign rst_to_async = rst_hit & sync_en_ff & (bus_byte == nrc_pkg::OP_RESET);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_en_ff <= 1'b0;
      tmode_ff <= nrc_pkg::CTRL_TMODE_RST;
    end else if (rst_to_async) begin
      sync_en_ff <= 1'b0;
      tmode_ff <= nrc_pkg::CTRL_TMODE_RST;
    end else if (ctrl_wr) begin
      sync_en_ff <= i_reg_wdata[nrc_pkg::CTRL_SYNC_BIT];
      tmode_ff <= i_reg_wdata[nrc_pkg::CTRL_TMODE_LSB +: 4];
    end
  end

  // sticky errors: a new set wins over a same-cycle clear
  logic [2:0] err_set;
  logic [2:0] nxt_err;

  assign err_set = {srst_err_set, cache_err_set, seq_err_set};
  assign nxt_err = (err_wr ? (err_ff & ~i_reg_wdata[2:0]) : err_ff) | err_set;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_ff <= 3'b000;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // ==========================================================================
  // array side outputs
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      op_valid_ff <= 1'b0;
      op_conf_ff <= 8'h00;
      abort_ff <= 1'b0;
    end else begin
      op_valid_ff <= op_fire;
      op_conf_ff <= op_fire ? bus_byte : op_conf_ff;
      abort_ff <= rst_hit;
    end
  end

  assign o_op_valid = op_valid_ff;
  assign o_op_first = first_ff;
  assign o_op_confirm = op_conf_ff;
  assign o_op_addr = addr_ff;
  assign o_abort = abort_ff;
  assign o_array_stop = rst_busy;
  assign o_rb_n = ~rst_busy;

  // ==========================================================================
  // identifier output path
  logic async_out_win;
  logic [7:0] cur_byte;

  assign async_out_win = ~sync_en_ff & sel & ~rd_n & id_out;
  assign cur_byte = id_byte(id_sig_ff, idx_ff);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dq_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      dqs_ff <= 1'b0;
      dqs_oe_ff <= 1'b0;
    end else begin
      if ((~sync_en_ff & sel & rd_fall & id_out) | (sync_out_win & lclk_rise)) begin
        dq_ff <= cur_byte;
      end
      if (sync_out_win & lclk_rise) begin
        dqs_ff <= 1'b1;
      end else if (lclk_fall | ~sync_out_win) begin
        dqs_ff <= 1'b0;
      end
      dq_oe_ff <= async_out_win | sync_out_win;
      dqs_oe_ff <= sync_out_win;
    end
  end

  assign o_dq = dq_ff;
  assign o_dq_oe = dq_oe_ff;
  assign o_dqs = dqs_ff;
  assign o_dqs_oe = dqs_oe_ff;

  // ==========================================================================
  // register read port
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign status_word = {16'h0000, last_ff, 3'b000, mp_ff, all_idle, id_out,
                        sync_en_ff, rst_busy};
  assign rd_mux = (i_reg_addr == nrc_pkg::REG_CTRL) ? {27'h0, sync_en_ff, tmode_ff} :
                  (i_reg_addr == nrc_pkg::REG_STATUS) ? status_word :
                  (i_reg_addr == nrc_pkg::REG_ERR) ? {29'h0, err_ff} : 32'h0;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= i_reg_rd ? rd_mux : 32'h0;
    end
  end

  assign o_reg_rdata = rdata_ff;

endmodule : nrc_top

// >>> tb/nrc_top_sva.sv
// nrc_top_sva: port checks for nrc_top.
// assumes the core clock domain only.
`timescale 1ns/1ns
module nrc_top_sva (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // watched outputs
  input wire logic [7:0] o_dq,
  input wire logic o_dq_oe,
  input wire logic o_dqs,
  input wire logic o_dqs_oe,
  input wire logic o_rb_n,
  input wire logic o_op_valid,
  input wire logic [7:0] o_op_first,
  input wire logic [7:0] o_op_confirm,
  input wire logic [8*nrc_pkg::ADDR_BYTES-1:0] o_op_addr,
  input wire logic o_abort,
  input wire logic o_array_stop
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // cycles of busy since the last abort
  logic [15:0] low_ff;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) low_ff <= 16'h0;
    else low_ff <= o_rb_n ? 16'h0 : (o_abort ? 16'h1 : low_ff + 16'h1);
  end
  property p_len; $rose(o_rb_n) |-> low_ff == 16'(nrc_pkg::RST_CYC); endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_busy; o_abort |-> !o_rb_n; endproperty
  a_busy: assert property (p_busy) else $error("no busy");
  property p_stop; o_abort |-> o_array_stop [*8]; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_clr; o_abort |-> ##[0:1] (o_op_addr == '0); endproperty
  a_clr: assert property (p_clr) else $error("addr kept");
  property p_er; o_op_valid && o_op_first == 8'h60 |-> o_op_confirm inside {8'hd0, 8'hd1};
  endproperty
  a_er: assert property (p_er) else $error("erase confirm");
  property p_cb; o_op_valid && o_op_first == 8'h85 |-> o_op_confirm inside {8'h10, 8'h11};
  endproperty
  a_cb: assert property (p_cb) else $error("copyback confirm");
  property p_rep; $fell(o_dqs) |-> $stable(o_dq); endproperty
  a_rep: assert property (p_rep) else $error("byte changed");
  property p_oe; o_dqs |-> o_dq_oe && o_dqs_oe; endproperty
  a_oe: assert property (p_oe) else $error("dq not driven");
endmodule : nrc_top_sva
bind nrc_top nrc_top_sva nrc_top_sva_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_rb_n(o_rb_n),
  .o_op_valid(o_op_valid),
  .o_op_first(o_op_first), .o_op_confirm(o_op_confirm), .o_op_addr(o_op_addr),
  .o_abort(o_abort), .o_array_stop(o_array_stop));

// >>> tb/nrc_host.sv
// nrc_host: host model for command, address and id cycles.
// assumes i_clk is the core clock; link clock runs only inside cycles.
`timescale 1ns/1ns
module nrc_host (
  // clock
  input wire logic i_clk,
  // pins
  input wire logic [7:0] i_dq,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_rd_stb_n,
  output logic o_lclk,
  output logic [7:0] o_dq,
  // seen id byte
  output logic o_got,
  output logic [7:0] o_byte
);
  logic sync = 1'b0;
  initial begin
    {o_ce_n, o_we_n, o_rd_stb_n, o_cle, o_ale, o_lclk, o_got} = 7'h70;
    {o_dq, o_byte} = 16'h0;
  end
  // command (c=1) or address cycle
  task automatic put(input logic c, input logic [7:0] b);
    @(posedge i_clk);
    {o_ce_n, o_cle, o_ale} <= {1'b0, c, !c};
    o_dq <= b;
    if (sync) begin
      // dq stands over both link clock edges
      #63 o_lclk = 1'b1;
      #62 o_lclk = 1'b0;
    end else begin
      repeat (4) @(posedge i_clk);
      o_we_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_we_n <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    {o_cle, o_ale} <= 2'b00;
    o_dq <= ~b;
  endtask : put
  // one id byte
  task automatic get();
    @(posedge i_clk);
    {o_cle, o_ale, o_we_n} <= {sync, sync, !sync};
    if (sync) begin
      #63 o_lclk = 1'b1;
      #58 o_byte = i_dq;
      #4 o_lclk = 1'b0;
    end else begin
      o_rd_stb_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_byte <= i_dq;
      o_rd_stb_n <= 1'b1;
    end
    @(posedge i_clk);
    o_got <= 1'b1;
    @(posedge i_clk);
    o_got <= 1'b0;
    repeat (4) @(posedge i_clk);
    {o_cle, o_ale, o_we_n} <= 3'b001;
  endtask : get
endmodule : nrc_host

// >>> tb/tb_nrc_top.sv
// tb_nrc_top: self-checking bench for nrc_top.
// assumes nrc_host drives the pins; array and registers driven here.
`timescale 1ns/1ns
module tb_nrc_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] die = 4'hf;
  logic arr_ok = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [63:0] rq;
  logic [63:0] q_op[$];
  logic [63:0] q_rd[$];
  logic [7:0] q_id[$];
  wire ce_n, cle, ale, we_n, rd_stb_n, lclk, got, op_v, rb_n;
  wire [7:0] hdq, ddq, hb, op_f, op_c;
  wire [39:0] op_a;
  wire [31:0] rdata;
  nrc_top nrc_top_i (.i_core_clk(clk), .i_nrst(nrst), .i_ce_n(ce_n), .i_cle(cle),
    .i_ale(ale), .i_we_n(we_n), .i_read_strobe_n(rd_stb_n), .i_link_clk(lclk), .i_dq(hdq),
    .o_dq(ddq), .o_dq_oe(), .o_dqs(), .o_dqs_oe(), .o_rb_n(rb_n), .i_die_rdy(die),
    .i_array_ready_flag(arr_ok), .o_op_valid(op_v), .o_op_first(op_f), .o_op_confirm(op_c),
    .o_op_addr(op_a), .o_abort(), .o_array_stop(), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  nrc_host nrc_host_i (.i_clk(clk), .i_dq(ddq), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale),
    .o_we_n(we_n), .o_rd_stb_n(rd_stb_n), .o_lclk(lclk), .o_dq(hdq), .o_got(got), .o_byte(hb));
  initial forever #5 clk = ~clk;
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    {ra, rd} <= {a, 1'b1};
    q_rd.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic op(input logic [7:0] f, input int n, input logic [7:0] c);
    logic [39:0] a;
    a = '0;
    nrc_host_i.put(1'b1, f);
    for (int i = 0; i < n; i++) begin
      a[8*i+:8] = 8'($urandom);
      nrc_host_i.put(1'b0, a[8*i+:8]);
    end
    q_op.push_back({f, c, a});
    nrc_host_i.put(1'b1, c);
  endtask : op
  task automatic cmd(input logic [7:0] c, input logic [7:0] a);
    nrc_host_i.put(1'b1, c);
    if (c == 8'h90) nrc_host_i.put(1'b0, a);
    else repeat (nrc_pkg::RST_CYC + 10) @(posedge clk); // covers change time
  endtask : cmd
  task automatic ids(input int n, input logic [39:0] v);
    for (int i = 0; i < n; i++) begin
      q_id.push_back(v[8*i+:8]);
      nrc_host_i.get();
    end
  endtask : ids
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    if (op_v) check("op", {op_f, op_c, op_a}, q_op.pop_front());
    if (got) check("id", hb, q_id.pop_front());
    if (rd_d) begin
      rq = q_rd.pop_front();
      check("reg", rdata & rq[63:32], rq[31:0]);
    end
    if (cyc > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h29b5ab1c));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rreg(4'h0, '1, 32'h0);
    rreg(4'hc, '1, 32'h0);
    cmd(8'hff, 8'h0); // first command after power-up, no status polls
    die <= 4'($urandom);
    op(8'h60, 3, 8'hd0);
    op(8'h60, 3, 8'hd1);
    op(8'h00, 5, 8'h32);
    op(8'h00, 5, 8'h35);
    op(8'h85, 5, 8'h10);
    op(8'h85, 5, 8'h11);
    op(8'h00, 5, 8'h32);
    op(8'h00, 5, 8'h32); // second pending multi-plane read flags ERR[0]
    arr_ok <= 1'b0;
    op(8'h80, 5, 8'h15); // cache program after a read while busy flags ERR[1]
    die <= 4'he;
    cmd(8'h90, 8'h00);
    rreg(4'h4, 32'h4, 32'h0);
    die <= 4'hf;
    cmd(8'h90, 8'h00);
    rreg(4'h4, 32'h4, 32'h4);
    ids(5, nrc_pkg::ID_CODE);
    cmd(8'h90, 8'h20);
    ids(4, {8'h0, nrc_pkg::ID_SIG});
    @(posedge clk);
    {ra, wd, wr} <= {4'h0, 32'h13, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    nrc_host_i.sync = 1'b1;
    cmd(8'h90, 8'h00);
    ids(2, nrc_pkg::ID_CODE);
    cmd(8'hfc, 8'h0);
    rreg(4'h4, 32'h2, 32'h2);
    cmd(8'hff, 8'h0);
    nrc_host_i.sync = 1'b0;
    rreg(4'h0, '1, 32'h0);
    @(posedge clk);
    {wd, wr} <= {32'h3, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    cmd(8'hfc, 8'h0);
    rreg(4'h8, 32'h7, 32'h7);
    cmd(8'hff, 8'h0);
    rreg(4'h0, '1, 32'h3);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_nrc_top
